//--- common/qlvt_pkg.sv
// package: constants and carriers for the quad-link enable-only video timing monitor
package qlvt_pkg;
	localparam int unsigned SYS_KHZ       = 125000;
	localparam int unsigned SYS_HZ        = 125000000;
	// per-link line and frame geometry in pixel clocks and lines
	localparam logic [11:0] H_ACTIVE      = 12'h1E0;
	localparam logic [11:0] H_BLANK_MIN   = 12'h028;
	localparam logic [11:0] H_BLANK_MAX   = 12'h0C8;
	localparam logic [10:0] V_ACTIVE      = 11'h438;
	localparam logic [8:0]  VB_HI_MIN     = 9'h014;
	localparam logic [8:0]  VB_HI_MAX     = 9'h056;
	localparam logic [8:0]  VB_LO_MIN     = 9'h0E4;
	localparam logic [8:0]  VB_LO_MAX     = 9'h12C;
	localparam logic [11:0] H_TOTAL_RST   = 12'h226;
	// pixel clock window, counted over a fixed span of system cycles
	localparam int unsigned PCLK_MIN_KHZ  = 66970;
	localparam int unsigned PCLK_MAX_KHZ  = 78000;
	localparam int unsigned PCLK_WIN      = 1024;
	localparam logic [10:0] PCLK_MIN_CNT  = 11'((PCLK_MIN_KHZ * PCLK_WIN + SYS_KHZ - 1) / SYS_KHZ);
	localparam logic [10:0] PCLK_MAX_CNT  = 11'((PCLK_MAX_KHZ * PCLK_WIN) / SYS_KHZ);
	// frame rate windows in hertz
	localparam int unsigned FR_HI_MIN_HZ  = 108;
	localparam int unsigned FR_HI_MAX_HZ  = 122;
	localparam int unsigned FR_LO_MIN_HZ  = 95;
	localparam int unsigned FR_LO_MAX_HZ  = 104;
	localparam int unsigned FR_HI_MIN_CYC = (SYS_HZ + FR_HI_MAX_HZ - 1) / FR_HI_MAX_HZ;
	localparam int unsigned FR_HI_MAX_CYC = SYS_HZ / FR_HI_MIN_HZ;
	localparam int unsigned FR_LO_MIN_CYC = (SYS_HZ + FR_LO_MAX_HZ - 1) / FR_LO_MAX_HZ;
	localparam int unsigned FR_LO_MAX_CYC = SYS_HZ / FR_LO_MIN_HZ;
	// register map
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_STATUS   = 8'h04;
	localparam logic [7:0]  ADDR_MASK     = 8'h08;
	localparam logic [7:0]  ADDR_PINS     = 8'h0C;
	localparam logic [7:0]  ADDR_MEAS     = 8'h10;
	localparam logic [0:0]  CTRL_RST      = 1'h0;
	localparam logic [6:0]  MASK_RST      = 7'h00;
	localparam int unsigned ST_HACT       = 0;
	localparam int unsigned ST_HBLK       = 1;
	localparam int unsigned ST_VACT       = 2;
	localparam int unsigned ST_VBLK       = 3;
	localparam int unsigned ST_PCLK       = 4;
	localparam int unsigned ST_FRATE      = 5;
	localparam int unsigned ST_FRAME      = 6;
	localparam logic [6:0]  FAULT_BITS    = 7'h3F;

	typedef struct packed {
		logic pclk;
		logic de;
		logic depth_sel;
		logic map_sel;
		logic ldim;
		logic pwm;
		logic bl_power;
	} qlvt_pins_t;

	typedef enum logic [1:0] {
		QLVT_HUNT  = 2'b00,
		QLVT_LOCK  = 2'b01
	} qlvt_state_t;
endpackage

//--- hw/qlvt_sync.sv
// two-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
module qlvt_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule

//--- hw/qlvt_monitor.sv
// enable-only framing monitor and backlight control for the quad-link panel input
// Contract
// - framing uses data enable only; sync inputs are ignored
// - extra lane pairs of links three and four used only in 10-bit
// - status pin driven low normally, released open on a fault
// - dimming input high lights while backlight power control is high, low blanks; open means full duty
// - depth select high or open gives 10-bit, low gives 8-bit
// - map select high gives JEIDA ordering, low or open VESA
// - local dimming enable high turns it on, low off
`timescale 1ns/1ps
module qlvt_monitor #(
	parameter int unsigned FR_HI_MIN = qlvt_pkg::FR_HI_MIN_CYC,
	parameter int unsigned FR_HI_MAX = qlvt_pkg::FR_HI_MAX_CYC,
	parameter int unsigned FR_LO_MIN = qlvt_pkg::FR_LO_MIN_CYC,
	parameter int unsigned FR_LO_MAX = qlvt_pkg::FR_LO_MAX_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        pixel_clock,
	input  wire logic        data_enable,
	input  wire logic        hsync,
	input  wire logic        vsync,
	input  wire logic        depth_select,
	input  wire logic        map_select,
	input  wire logic        local_dimming_enable,
	input  wire logic        external_dimming_pwm,
	input  wire logic        backlight_power_control,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             irq,
	output logic             bl_status_o,
	output logic             bl_status_oe_n,
	output logic             backlight_on,
	output logic             local_dimming_on,
	output logic             lane_e_used,
	output logic             jeida_map
);
	qlvt_pkg::qlvt_pins_t pins_raw;
	qlvt_pkg::qlvt_pins_t pins_s;
	qlvt_pkg::qlvt_state_t state_r;
	logic        pclk_d_r;
	logic        de_prev_r;
	logic        pclk_rise;
	logic        de_rise;
	logic        de_fall;
	logic [11:0] run_r;
	logic [11:0] htotal_r;
	logic [11:0] vb_sub_r;
	logic [8:0]  vb_lines_r;
	logic [10:0] line_cnt_r;
	logic [11:0] hblank_last_r;
	logic [20:0] frame_cyc_r;
	logic [9:0]  win_r;
	logic [10:0] edge_cnt_r;
	logic [1:0]  sync_vld_r;
	logic [0:0]  ctrl_r;
	logic [6:0]  status_r;
	logic [6:0]  mask_r;
	logic [6:0]  evt;
	logic [6:0]  clr;
	logic        vb_bad;
	logic        fr_bad;
	logic        fault;

	// hsync and vsync are deliberately not sampled
	assign pins_raw = '{pclk: pixel_clock, de: data_enable, depth_sel: depth_select, map_sel: map_select,
		ldim: local_dimming_enable, pwm: external_dimming_pwm, bl_power: backlight_power_control};

	qlvt_sync #(.W($bits(qlvt_pkg::qlvt_pins_t))) u_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.d       (pins_raw),
		.q       (pins_s)
	);

	// synchroniser output reads zero until filled; keeps lane_e_used from glitching low after reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync_vld_r <= 2'b00;
		end else begin
			sync_vld_r <= {sync_vld_r[0], 1'b1};
		end
	end

	// de shares the pclk sync path so both stay aligned at the sampled edge
	assign pclk_rise = pins_s.pclk & ~pclk_d_r;
	assign de_rise   = pclk_rise & pins_s.de & ~de_prev_r;
	assign de_fall   = pclk_rise & ~pins_s.de & de_prev_r;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pclk_d_r  <= 1'b0;
			de_prev_r <= 1'b0;
		end else begin
			pclk_d_r <= pins_s.pclk;
			if (pclk_rise) begin
				de_prev_r <= pins_s.de;
			end
		end
	end

	// run length of the current enable level, saturating
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			run_r <= 12'h000;
		end else if (de_rise || de_fall) begin
			run_r <= 12'h001;
		end else if (pclk_rise && run_r != 12'hFFF) begin
			run_r <= run_r + 12'h001;
		end
	end

	// vertical blank lines counted in units of the last line total
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			vb_sub_r   <= 12'h000;
			vb_lines_r <= 9'h000;
		end else if (de_fall) begin
			vb_sub_r   <= 12'h001;
			vb_lines_r <= 9'h000;
		end else if (pclk_rise && !pins_s.de) begin
			if (vb_sub_r >= htotal_r - 12'h001) begin
				vb_sub_r <= 12'h000;
				if (vb_lines_r != 9'h1FF) begin
					vb_lines_r <= vb_lines_r + 9'h001;
				end
			end else begin
				vb_sub_r <= vb_sub_r + 12'h001;
			end
		end
	end

	logic vb_window;
	assign vb_window = de_rise && run_r > qlvt_pkg::H_BLANK_MAX;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			line_cnt_r    <= 11'h000;
			htotal_r      <= qlvt_pkg::H_TOTAL_RST;
			hblank_last_r <= 12'h000;
			state_r       <= qlvt_pkg::QLVT_HUNT;
		end else if (de_rise) begin
			if (vb_window) begin
				line_cnt_r <= 11'h001;
				state_r    <= qlvt_pkg::QLVT_LOCK;
			end else begin
				line_cnt_r    <= line_cnt_r + 11'h001;
				hblank_last_r <= run_r;
				htotal_r      <= run_r + qlvt_pkg::H_ACTIVE;
			end
		end
	end

	assign vb_bad = ctrl_r[0] ? (vb_lines_r < qlvt_pkg::VB_LO_MIN || vb_lines_r > qlvt_pkg::VB_LO_MAX)
		: (vb_lines_r < qlvt_pkg::VB_HI_MIN || vb_lines_r > qlvt_pkg::VB_HI_MAX);
	assign fr_bad = ctrl_r[0] ? (frame_cyc_r < 21'(FR_LO_MIN) || frame_cyc_r > 21'(FR_LO_MAX))
		: (frame_cyc_r < 21'(FR_HI_MIN) || frame_cyc_r > 21'(FR_HI_MAX));

	// frame period in system cycles
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			frame_cyc_r <= 21'h000000;
		end else if (vb_window) begin
			frame_cyc_r <= 21'h000001;
		end else if (frame_cyc_r != 21'h1FFFFF) begin
			frame_cyc_r <= frame_cyc_r + 21'h000001;
		end
	end

	// pixel clock edges counted over a fixed window
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			win_r      <= 10'h000;
			edge_cnt_r <= 11'h000;
		end else begin
			win_r <= win_r + 10'h001;
			if (win_r == 10'h3FF) begin
				edge_cnt_r <= {10'h000, pclk_rise};
			end else if (pclk_rise) begin
				edge_cnt_r <= edge_cnt_r + 11'h001;
			end
		end
	end

	logic locked;
	assign locked = state_r == qlvt_pkg::QLVT_LOCK;

	always_comb begin
		evt = 7'h00;
		evt[qlvt_pkg::ST_HACT]  = de_fall && run_r != qlvt_pkg::H_ACTIVE;
		evt[qlvt_pkg::ST_HBLK]  = de_rise && !vb_window && line_cnt_r != 11'h000
			&& run_r < qlvt_pkg::H_BLANK_MIN;
		evt[qlvt_pkg::ST_VACT]  = vb_window && locked && line_cnt_r != qlvt_pkg::V_ACTIVE;
		evt[qlvt_pkg::ST_VBLK]  = vb_window && locked && vb_bad;
		evt[qlvt_pkg::ST_PCLK]  = win_r == 10'h3FF && (edge_cnt_r < qlvt_pkg::PCLK_MIN_CNT
			|| edge_cnt_r > qlvt_pkg::PCLK_MAX_CNT);
		evt[qlvt_pkg::ST_FRATE] = vb_window && locked && fr_bad;
		evt[qlvt_pkg::ST_FRAME] = vb_window;
	end

	assign clr = (reg_wr && reg_addr == qlvt_pkg::ADDR_STATUS) ? reg_wdata[6:0] : 7'h00;

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			status_r <= 7'h00;
		end else begin
			status_r <= (status_r & ~clr) | evt;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= qlvt_pkg::CTRL_RST;
			mask_r <= qlvt_pkg::MASK_RST;
		end else if (reg_wr) begin
			if (reg_addr == qlvt_pkg::ADDR_CTRL) begin
				ctrl_r <= reg_wdata[0:0];
			end else if (reg_addr == qlvt_pkg::ADDR_MASK) begin
				mask_r <= reg_wdata[6:0];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			if (reg_addr == qlvt_pkg::ADDR_CTRL) begin
				reg_rdata <= {31'h00000000, ctrl_r};
			end else if (reg_addr == qlvt_pkg::ADDR_STATUS) begin
				reg_rdata <= {25'h0000000, status_r};
			end else if (reg_addr == qlvt_pkg::ADDR_MASK) begin
				reg_rdata <= {25'h0000000, mask_r};
			end else if (reg_addr == qlvt_pkg::ADDR_PINS) begin
				reg_rdata <= {27'h0000000, backlight_on, local_dimming_on, jeida_map, lane_e_used, locked};
			end else if (reg_addr == qlvt_pkg::ADDR_MEAS) begin
				reg_rdata <= {4'h0, hblank_last_r, 5'h00, line_cnt_r};
			end else begin
				reg_rdata <= 32'h00000000;
			end
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	assign fault = |(status_r & qlvt_pkg::FAULT_BITS);

	// pin outputs; open pins rely on board pulls, so open depth reads high and open map reads low
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq              <= 1'b0;
			bl_status_o      <= 1'b0;
			bl_status_oe_n   <= 1'b0;
			backlight_on     <= 1'b0;
			local_dimming_on <= 1'b0;
			lane_e_used      <= 1'b1;
			jeida_map        <= 1'b0;
		end else begin
			irq              <= |(status_r & mask_r);
			bl_status_o      <= 1'b0;
			bl_status_oe_n   <= fault;
			backlight_on     <= pins_s.pwm & pins_s.bl_power;
			local_dimming_on <= pins_s.ldim;
			lane_e_used      <= pins_s.depth_sel | ~sync_vld_r[1];
			jeida_map        <= pins_s.map_sel;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_status_release: assert property (fault |=> bl_status_oe_n) else $error("status not released on fault");
	a_status_drive: assert property (!fault |=> !bl_status_oe_n && !bl_status_o) else $error("status not low");
	a_pwm_follow: assert property ($rose(pins_s.pwm) && pins_s.bl_power ##1 pins_s.bl_power |-> backlight_on)
		else $error("backlight not lit by pwm");
	a_depth_lane: assert property ($changed(pins_s.depth_sel) |=> lane_e_used == $past(pins_s.depth_sel))
		else $error("lane use wrong for depth");
	a_map_sel: assert property (pins_s.map_sel [*2] |-> ##1 jeida_map) else $error("map select ignored");
	a_ldim_sel: assert property (!pins_s.ldim [*2] |-> ##1 !local_dimming_on) else $error("ldim not off");
	a_hact_err: assert property (de_fall && run_r != qlvt_pkg::H_ACTIVE |=> status_r[qlvt_pkg::ST_HACT])
		else $error("bad active length not flagged");
	a_hact_ok: assert property (de_fall && run_r == qlvt_pkg::H_ACTIVE && !status_r[qlvt_pkg::ST_HACT]
		&& !reg_wr |=> !status_r[qlvt_pkg::ST_HACT]) else $error("good active length flagged");
	a_hblk_err: assert property (de_rise && run_r == 12'h027 && line_cnt_r != 11'h000
		|=> status_r[qlvt_pkg::ST_HBLK]) else $error("short blank not flagged");
	a_vact_err: assert property (vb_window && locked && line_cnt_r != qlvt_pkg::V_ACTIVE
		|=> status_r[qlvt_pkg::ST_VACT]) else $error("line count error missed");
	a_vblk_err: assert property (vb_window && locked && vb_bad |=> status_r[qlvt_pkg::ST_VBLK])
		else $error("vertical blank error missed");
	a_pclk_err: assert property (win_r == 10'h3FF && edge_cnt_r < qlvt_pkg::PCLK_MIN_CNT
		|=> status_r[qlvt_pkg::ST_PCLK]) else $error("slow pixel clock missed");
	a_frate_err: assert property (vb_window && locked && fr_bad |=> status_r[qlvt_pkg::ST_FRATE])
		else $error("frame rate error missed");
	a_run_restart: assert property (de_rise || de_fall |=> run_r == 12'h001) else $error("run not restarted");
	a_irq_level: assert property (|(status_r & mask_r) |=> irq) else $error("irq not raised");

	c_frame: cover property (vb_window && locked && !vb_bad && line_cnt_r == qlvt_pkg::V_ACTIVE);
	c_fault: cover property ($rose(bl_status_oe_n));
	c_line: cover property (de_fall && run_r == qlvt_pkg::H_ACTIVE);
	c_clear: cover property (reg_wr && reg_addr == qlvt_pkg::ADDR_STATUS && |status_r);
endmodule

//--- test/qlvt_host.sv
// host video source model: enable-only framing over one link clock
`timescale 1ns/1ps
module qlvt_host (
	output logic pixel_clock,
	output logic data_enable,
	output logic hsync,
	output logic vsync
);
	localparam time HALF = 32ns;

	initial begin
		pixel_clock = 1'b0;
		data_enable = 1'b0;
		hsync = 1'b0;
		vsync = 1'b0;
	end

	// one pixel clock; clock stands low between calls, no spreading so no margin needed
	task automatic tick(input logic de);
		data_enable = de;
		#HALF pixel_clock = 1'b1;
		#HALF pixel_clock = 1'b0;
	endtask

	// sync lines carry junk on purpose: the panel must not care
	// line total is act plus blk, so line rate tracks the link clock
	task automatic send_line(input int act, input int blk);
		vsync = ~vsync;
		hsync = 1'b1;
		repeat (act) tick(1'b1);
		hsync = 1'b0;
		repeat (blk) tick(1'b0);
	endtask
endmodule

//--- test/tb.sv
// testbench: registers, pins, backlight status and line timing checks
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb;
	logic        clk_sys;
	logic        rst_n;
	logic        pixel_clock;
	logic        data_enable;
	logic        hsync;
	logic        vsync;
	logic        depth_select;
	logic        map_select;
	logic        local_dimming_enable;
	logic        external_dimming_pwm;
	logic        backlight_power_control;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        irq;
	logic        bl_status_o;
	logic        bl_status_oe_n;
	logic        backlight_on;
	logic        local_dimming_on;
	logic        lane_e_used;
	logic        jeida_map;
	logic [31:0] d;
	int          bad_count;
	int          n_compared;
	int          cycles;

	qlvt_host host (.pixel_clock(pixel_clock), .data_enable(data_enable), .hsync(hsync), .vsync(vsync));

	qlvt_monitor #(.FR_HI_MIN(1000), .FR_HI_MAX(10000), .FR_LO_MIN(1000), .FR_LO_MAX(200000)) dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .pixel_clock(pixel_clock), .data_enable(data_enable),
		.hsync(hsync), .vsync(vsync), .depth_select(depth_select), .map_select(map_select),
		.local_dimming_enable(local_dimming_enable), .external_dimming_pwm(external_dimming_pwm),
		.backlight_power_control(backlight_power_control), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .bl_status_o(bl_status_o),
		.bl_status_oe_n(bl_status_oe_n), .backlight_on(backlight_on), .local_dimming_on(local_dimming_on),
		.lane_e_used(lane_e_used), .jeida_map(jeida_map));

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic print_verdict();
		$display("compared %0d, wrong %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// hang guard: about 77k cycles of traffic expected
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 95000) begin
			bad_count++;
			print_verdict();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	initial begin
		rst_n = 1'b0;
		depth_select = 1'b1;
		map_select = 1'b0;
		local_dimming_enable = 1'b1;
		external_dimming_pwm = 1'b1;
		backlight_power_control = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		settle(1);
		`CHK(bl_status_oe_n, 1'b0)
		`CHK(bl_status_o, 1'b0)
		settle(4);
		rd(qlvt_pkg::ADDR_PINS);
		`CHK(d, 32'h0000001A)
		rd(qlvt_pkg::ADDR_MASK);
		`CHK(d, 32'h00000000)
		rd(8'h14);
		`CHK(d, 32'h00000000)
		$display("test reset done");

		@(posedge clk_sys);
		depth_select <= 1'b0;
		map_select <= 1'b1;
		local_dimming_enable <= 1'b0;
		external_dimming_pwm <= 1'b0;
		settle(4);
		`CHK(lane_e_used, 1'b0)
		`CHK(jeida_map, 1'b1)
		`CHK(local_dimming_on, 1'b0)
		`CHK(backlight_on, 1'b0)
		rd(qlvt_pkg::ADDR_PINS);
		`CHK(d, 32'h00000004)
		// host keeps local dimming on and the panel in 10-bit from here
		local_dimming_enable <= 1'b1;
		depth_select <= 1'b1;
		map_select <= 1'b0;
		external_dimming_pwm <= 1'b1;
		settle(4);
		`CHK(backlight_on, 1'b1)
		$display("test pins done");

		// link clock still: pixel count falls below its window
		settle(2200);
		rd(qlvt_pkg::ADDR_STATUS);
		`CHK(d[4], 1'b1)
		`CHK(bl_status_oe_n, 1'b1)
		`CHK(bl_status_o, 1'b0)
		wr(qlvt_pkg::ADDR_MASK, 32'h00000003);
		wr(qlvt_pkg::ADDR_STATUS, 32'h0000007F);
		settle(2);
		`CHK(irq, 1'b0)
		$display("test idle clock done");

		host.send_line(0, 70);
		repeat (4) host.send_line(480, 70);
		settle(8);
		rd(qlvt_pkg::ADDR_MEAS);
		`CHK(d[27:16], 12'h046)
		`CHK(d[10:0], 11'h004)
		host.send_line(480, 40);
		host.send_line(480, 200);
		host.send_line(480, 70);
		settle(8);
		rd(qlvt_pkg::ADDR_STATUS);
		`CHK(d[1:0], 2'b00)
		`CHK(irq, 1'b0)
		$display("test good lines done");

		host.send_line(479, 70);
		host.send_line(480, 39);
		host.send_line(480, 70);
		settle(8);
		rd(qlvt_pkg::ADDR_STATUS);
		`CHK(d[1:0], 2'b11)
		`CHK(irq, 1'b1)
		rd(qlvt_pkg::ADDR_MEAS);
		`CHK(d[27:16], 12'h027)
		wr(qlvt_pkg::ADDR_STATUS, 32'h00000003);
		settle(2);
		`CHK(irq, 1'b0)
		rd(qlvt_pkg::ADDR_STATUS);
		`CHK(d[1:0], 2'b00)
		$display("test bad lines done");

		// short frames: few lines and a thin vertical blank; frame period only fits the low-rate window
		wr(qlvt_pkg::ADDR_MASK, 32'h00000020);
		host.send_line(0, 300);
		repeat (2) host.send_line(480, 70);
		host.send_line(0, 300);
		host.send_line(480, 70);
		settle(8);
		rd(qlvt_pkg::ADDR_STATUS);
		`CHK(d[6:5], 2'b11)
		`CHK(d[3:2], 2'b11)
		`CHK(d[1:0], 2'b00)
		`CHK(irq, 1'b1)
		rd(qlvt_pkg::ADDR_PINS);
		`CHK(d[0], 1'b1)
		wr(qlvt_pkg::ADDR_STATUS, 32'h0000007F);
		wr(qlvt_pkg::ADDR_CTRL, 32'h00000001);
		rd(qlvt_pkg::ADDR_CTRL);
		`CHK(d, 32'h00000001)
		host.send_line(480, 70);
		host.send_line(0, 300);
		host.send_line(480, 70);
		settle(8);
		rd(qlvt_pkg::ADDR_STATUS);
		`CHK(d[6:5], 2'b10)
		`CHK(d[3:2], 2'b11)
		`CHK(irq, 1'b0)
		$display("test frames done");
		print_verdict();
	end
endmodule
